/* File: dv/adl_rx_model.sv */
/*
 * Behavioural serial receiver for the link datapath bench.
 * Assumes octets and K flags straight from the transmitter, same clock.
 */
`timescale 1ns/100ps
module adl_rx_model (
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        reset_i,
    // Bench control: force a new code group sync
    input  wire        resync_i,
    // Link from the transmitter
    input  wire [15:0] link_data_i,
    input  wire [1:0]  link_is_k_i,
    input  wire        link_valid_i,
    // Sync request, active low
    output reg         sync_n_o
);
    // ***************************************************
    // Comma counting
    // ***************************************************
    reg  [2:0] comma_q;
    // A comma leads every sync frame, with or without idle pairing
    wire       comma_c = link_valid_i && link_is_k_i[1]
                         && (link_data_i[15:8] == 8'hBC);

    always @(posedge core_clk_i)
    begin
        if (reset_i || resync_i)
        begin
            comma_q  <= 3'h0;
            sync_n_o <= 1'b0;
        end
        else if (!comma_c)
            comma_q <= 3'h0;
        else if (comma_q == 3'h7)
            sync_n_o <= 1'b1;
        else
            comma_q <= comma_q + 3'h1;
    end
endmodule // adl_rx_model

/* File: dv/adl_tx_datapath_sva.sv */
/*
 * Assertion checker for the link datapath control block.
 * Assumes it is bound to adl_tx_datapath and sees only its ports.
 */
`timescale 1ns/100ps
`include "adl_regs.vh"
module adl_tx_datapath_sva #(
    parameter MF_FRAMES = 9
) (
    // Clock and reset
    input wire        core_clk_i,
    input wire        reset_i,
    // Samples and link control
    input wire [13:0] adc_data_i,
    input wire        scramble_enable_i,
    input wire        sync_n_i,
    // Register bus
    input wire [9:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0]  avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    // Link and sample outputs
    input wire [15:0] link_data_o,
    input wire [1:0]  link_is_k_o,
    input wire        link_valid_o,
    input wire [13:0] sample_o
);
    // ***************************************************
    // Register shadows
    // ***************************************************
    // The checker cannot see the bodies, so it follows the bus writes
    reg  [7:0] gp_q;
    reg  [7:0] lk_q;
    reg  [7:0] hi_q;
    reg  [7:0] lo_q;
    reg        pdn_q;
    reg  [3:0] age_q;
    wire       wr_c = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire [7:0] idx_c = avs_address_i[9:2];
    // Settle time after a write covers the sample pipeline depth
    wire       ok_c = !pdn_q && (age_q > 4'h5);

    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            gp_q  <= 8'h00;
            lk_q  <= 8'h00;
            hi_q  <= 8'h00;
            lo_q  <= 8'h00;
            pdn_q <= 1'b0;
            age_q <= 4'h0;
        end
        else
        begin
            age_q <= wr_c ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
            if (wr_c && idx_c == `ADL_IDX_GAIN_PAT)
                gp_q <= avs_writedata_i[7:0];
            if (wr_c && idx_c == `ADL_IDX_LINK_ALIGN)
                lk_q <= avs_writedata_i[7:0];
            if (wr_c && idx_c == `ADL_IDX_PAT_HI)
                hi_q <= avs_writedata_i[7:0];
            if (wr_c && idx_c == `ADL_IDX_PAT_LO)
                lo_q <= avs_writedata_i[7:0];
            if (wr_c && idx_c == `ADL_IDX_PWR_REF)
                pdn_q <= avs_writedata_i[6];
        end
    end

    // ***************************************************
    // Properties
    // ***************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    a_wait_single: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus request not answered");
    a_pat_min: assert property (ok_c && gp_q[2:0] == `ADL_PAT_MIN
        |-> sample_o == 14'h0000) else $error("minimum pattern wrong");
    a_pat_max: assert property (ok_c && gp_q[2:0] == `ADL_PAT_MAX
        |-> sample_o == 14'h3FFF) else $error("maximum pattern wrong");
    a_pat_user: assert property (ok_c && gp_q[2:0] == `ADL_PAT_USER
        |-> sample_o == {hi_q, lo_q[7:2]}) else $error("user pattern wrong");
    a_pass_unity: assert property (ok_c && gp_q[2:0] == `ADL_PAT_ADC
        && (gp_q[3] || gp_q[7:4] == 4'h0) |-> sample_o == $past(adc_data_i, 2))
        else $error("sample not passed unchanged");
    a_ramp_step: assert property (ok_c && age_q == 4'hF && gp_q[2:0] == `ADL_PAT_RAMP
        |-> sample_o == $past(sample_o, 4) + 14'h0001) else $error("ramp step wrong");
    a_pdn_link: assert property (pdn_q && age_q > 4'h2
        |-> !link_valid_o && link_data_o == 16'h0000) else $error("link active in power-down");
    a_sync_comma: assert property ((!sync_n_i && ok_c && !lk_q[5])[*4]
        |-> link_data_o == 16'hBCBC && link_is_k_o == 2'b11) else $error("sync commas wrong");
    a_idle_pair: assert property ((!sync_n_i && ok_c && lk_q[5])[*4]
        |-> link_is_k_o == 2'b10 && link_data_o[15:8] == 8'hBC
        && (link_data_o[7:0] == 8'hC5 || link_data_o[7:0] == 8'h50))
        else $error("idle ordered set wrong");
    // Scrambled octets hit FC only by chance, so the bench runs long scrambled
    a_scr_frame_align_pin: assert property ($past(scramble_enable_i) && ok_c && lk_q[1]
        && link_valid_o && link_data_o[7:0] == 8'hFC |-> link_is_k_o[0])
        else $error("scrambled FC octet not sent as control");
endmodule // adl_tx_datapath_sva

bind adl_tx_datapath adl_tx_datapath_sva #(.MF_FRAMES(MF_FRAMES)) u_sva (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .adc_data_i(adc_data_i),
    .scramble_enable_i(scramble_enable_i), .sync_n_i(sync_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .link_data_o(link_data_o), .link_is_k_o(link_is_k_o), .link_valid_o(link_valid_o),
    .sample_o(sample_o)
);

/* File: dv/testbench.sv */
/*
 * Self-checking bench for the link datapath control block.
 * Assumes the receiver model raises sync after a run of commas.
 */
`timescale 1ns/100ps
`include "adl_regs.vh"
module testbench;
    // ***************************************************
    // Signals
    // ***************************************************
    reg         core_clk_i;
    reg         reset_i;
    reg  [13:0] adc_data_i;
    reg  [9:0]  avs_address_i;
    reg         avs_read_i;
    reg         avs_write_i;
    reg  [31:0] avs_writedata_i;
    reg         resync;
    reg         scr;
    wire        sync_n;
    wire [31:0] avs_readdata_o;
    wire        avs_waitrequest_o;
    wire [15:0] link_data_o;
    wire [1:0]  link_is_k_o;
    wire        link_valid_o;
    wire [13:0] sample_o;
    reg  [7:0]  rd;
    reg  [13:0] ramp;
    integer     num_errors;
    integer     tests_run;

    adl_tx_datapath #(.MF_FRAMES(3)) dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .adc_data_i(adc_data_i),
        .scramble_enable_i(scr), .sync_n_i(sync_n), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .link_data_o(link_data_o), .link_is_k_o(link_is_k_o),
        .link_valid_o(link_valid_o), .sample_o(sample_o)
    );
    adl_rx_model rx (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .resync_i(resync),
        .link_data_i(link_data_o), .link_is_k_i(link_is_k_o),
        .link_valid_i(link_valid_o), .sync_n_o(sync_n)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = !core_clk_i;
    end

    // ***************************************************
    // Tasks
    // ***************************************************
    task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("BAD %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    task results;
    begin
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    // Holds the request until waitrequest is sampled low
    task bus(input w, input [7:0] idx, input [7:0] wd);
        integer n;
    begin
        @(posedge core_clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_writedata_i <= {{24{1'b0}}, wd};
        n = 0;
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 50)
        begin
            n = n + 1;
            @(posedge core_clk_i);
        end
        rd = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        check("bus", n < 50, 1);
        if (n == 50)
            results;
    end
    endtask

    task rdchk(input [7:0] idx, input [7:0] exp);
    begin
        bus(1'b0, idx, 8'h00);
        check("reg", rd, exp);
    end
    endtask

    task wait_link(input [15:0] mask, input [15:0] d, input [1:0] k);
        integer n;
    begin
        n = 0;
        @(posedge core_clk_i);
        while (((link_data_o & mask) !== d || link_is_k_o !== k) && n < 300)
        begin
            n = n + 1;
            @(posedge core_clk_i);
        end
        check("link", {link_is_k_o, link_data_o & mask}, {k, d});
        if (n == 300)
            results;
    end
    endtask

    task samp(input [13:0] exp);
    begin
        repeat (8) @(posedge core_clk_i);
        check("sample", sample_o, exp);
    end
    endtask

    task relink;
    begin
        @(posedge core_clk_i);
        resync <= 1'b1;
        @(posedge core_clk_i);
        resync <= 1'b0;
    end
    endtask

    function [13:0] rev14(input [13:0] v);
        integer b;
    begin
        for (b = 0; b < 14; b = b + 1)
            rev14[b] = v[13 - b];
    end
    endfunction

    // ***************************************************
    // Sequence
    // ***************************************************
    initial
    begin
        reset_i = 1'b1;
        adc_data_i = 14'h2345;
        avs_address_i = 10'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0000_0000;
        resync = 1'b0;
        scr = 1'b0;
        num_errors = 0;
        tests_run = 0;
        repeat (5) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rdchk(`ADL_IDX_PWR_REF, 8'h00);
        rdchk(`ADL_IDX_GAIN_PAT, 8'h00);
        rdchk(`ADL_IDX_LINK_ALIGN, 8'h00);
        bus(1'b1, 8'h10, 8'hA5);
        rdchk(8'h10, 8'h00);
        bus(1'b1, `ADL_IDX_PAT_HI, 8'h48);
        bus(1'b1, `ADL_IDX_PAT_LO, 8'hD0);
        rdchk(`ADL_IDX_PAT_HI, 8'h48);
        bus(1'b1, `ADL_IDX_GAIN_PAT, 8'h09);
        samp(14'h0000);
        bus(1'b1, `ADL_IDX_GAIN_PAT, 8'h0A);
        samp(14'h3FFF);
        bus(1'b1, `ADL_IDX_GAIN_PAT, 8'h08);
        samp(14'h2345);
        bus(1'b1, `ADL_IDX_GAIN_PAT, 8'h00);
        samp(14'h2345);
        bus(1'b1, `ADL_IDX_GAIN_PAT, 8'hC0);
        repeat (8) @(posedge core_clk_i);
        check("gain", sample_o > 14'h2345, 1);
        bus(1'b1, `ADL_IDX_GAIN_PAT, 8'h0C);
        repeat (16) @(posedge core_clk_i);
        ramp = sample_o + 14'h0001;
        repeat (4) @(posedge core_clk_i);
        check("ramp", sample_o, ramp);
        bus(1'b1, `ADL_IDX_GAIN_PAT, 8'h0D);
        rdchk(`ADL_IDX_GAIN_PAT, 8'h0D);
        samp(14'h1234);
        wait_link(16'hFFFF, 16'h48D0, 2'b00);
        bus(1'b1, `ADL_IDX_LINK_ALIGN, 8'h08);
        wait_link(16'hFFFF, {rev14(14'h1234), 2'b00}, 2'b00);
        bus(1'b1, `ADL_IDX_LINK_ALIGN, 8'h02);
        wait_link(16'hFFFF, 16'h48FC, 2'b01);
        bus(1'b1, `ADL_IDX_LINK_ALIGN, 8'h04);
        wait_link(16'hFFFF, 16'h487C, 2'b01);
        bus(1'b1, `ADL_IDX_LINK_ALIGN, 8'h06);
        scr <= 1'b1;
        repeat (1000) @(posedge core_clk_i);
        check("scr", link_data_o != 16'h48D0, 1);
        scr <= 1'b0;
        bus(1'b1, `ADL_IDX_LINK_ALIGN, 8'h10);
        wait_link(16'hFFFF, 16'hB5B5, 2'b00);
        bus(1'b1, `ADL_IDX_LINK_ALIGN, 8'h20);
        relink;
        wait_link(16'hFFFF, 16'hBCC5, 2'b10);
        wait_link(16'hFFFF, 16'hBC50, 2'b10);
        bus(1'b1, `ADL_IDX_LINK_ALIGN, 8'h01);
        relink;
        wait_link(16'hFFFF, 16'hBCBC, 2'b11);
        wait_link(16'hFF00, 16'h1C00, 2'b10);
        wait_link(16'hFFFF, 16'h48D0, 2'b00);
        bus(1'b1, `ADL_IDX_PWR_REF, 8'h40);
        repeat (4) @(posedge core_clk_i);
        check("valid", link_valid_o, 0);
        bus(1'b0, `ADL_IDX_STATUS, 8'h00);
        check("pdn", rd[2], 1);
        bus(1'b1, `ADL_IDX_PWR_REF, 8'h00);
        wait_link(16'hFFFF, 16'h48D0, 2'b00);
        // Second reset in mid-run must clear the registers again
        reset_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rdchk(`ADL_IDX_GAIN_PAT, 8'h00);
        results;
    end
endmodule // testbench

/* File: hdl/adl_regs.vh */
/*
 * Register map, field positions, reset values and link constants for the
 * converter link datapath control block.
 * Assumes byte addressing on the register bus, one 32-bit word per register.
 */
`ifndef ADL_REGS_VH
`define ADL_REGS_VH

// ***************************************************
// Register indices (byte address is four times these)
// ***************************************************
`define ADL_IDX_PAT_HI      8'h3E
`define ADL_IDX_PAT_LO      8'h3F
`define ADL_IDX_PWR_REF     8'h44
`define ADL_IDX_GAIN_PAT    8'h45
`define ADL_IDX_LINK_ALIGN  8'hA0
`define ADL_IDX_STATUS      8'hC0

// ***************************************************
// Field positions
// ***************************************************
`define ADL_PWR_PDN_BIT     6
`define ADL_GAIN_MSB        7
`define ADL_GAIN_LSB        4
`define ADL_GAIN_BYP_BIT    3
`define ADL_PAT_MSB         2
`define ADL_PAT_LSB         0
`define ADL_LNK_ILAS_BIT    0
`define ADL_LNK_FRAME_ALIGN_PIN_BIT  1
`define ADL_LNK_MULTIFRAME_ALIGN_ENABLE_BIT 2
`define ADL_LNK_FLIP_BIT    3
`define ADL_LNK_TEST_BIT    4
`define ADL_LNK_IDLE_BIT    5

// ***************************************************
// Reset values and encodings
// ***************************************************
`define ADL_RST_BYTE        8'h00
`define ADL_PAT_ADC         3'h0
`define ADL_PAT_MIN         3'h1
`define ADL_PAT_MAX         3'h2
`define ADL_PAT_RAMP        3'h4
`define ADL_PAT_USER        3'h5
`define ADL_RAMP_DIV        2'h3
`define ADL_ILAS_MFRAMES    2'h3
`define ADL_K28_0           8'h1C
`define ADL_K28_3           8'h7C
`define ADL_K28_5           8'hBC
`define ADL_K28_7           8'hFC
`define ADL_D5_6            8'hC5
`define ADL_D16_2           8'h50
`define ADL_D21_5           8'hB5

`endif

/* File: hdl/adl_tx_datapath.v */
/*
 * Converter link transmit datapath control: fine gain, test patterns, bus flip,
 * optional scrambling, code group sync, lane alignment, alignment characters,
 * and an Avalon-MM register slave with waitrequest.
 * Assumes one sample per clock, two octets per frame, inputs synchronous to
 * core_clk_i, and an 8b/10b coder downstream taking octets plus K flags.
 */
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
`include "adl_regs.vh"

module adl_tx_datapath #(
    parameter MF_FRAMES = 9
) (
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        reset_i,
    // Converter samples and link control
    input  wire [13:0] adc_data_i,
    input  wire        scramble_enable_i,
    input  wire        sync_n_i,
    // Avalon-MM slave
    input  wire [9:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // Link octets, high octet first, low octet ends the frame
    output reg  [15:0] link_data_o,
    output reg  [1:0]  link_is_k_o,
    output reg         link_valid_o,
    output reg  [13:0] sample_o
);

    localparam ST_CGS  = 2'd0;
    localparam ST_ILAS = 2'd1;
    localparam ST_DATA = 2'd2;

    // ***************************************************
    // Functions
    // ***************************************************
    // Q12 gain coefficient, 4096 is unity; codes 12 and above hold 6 dB
    function [13:0] gain_coef;
        input [3:0] g;
        begin
            case (g)
                4'h0:    gain_coef = 14'h1000;
                4'h1:    gain_coef = 14'h10F3;
                4'h2:    gain_coef = 14'h11F4;
                4'h3:    gain_coef = 14'h1304;
                4'h4:    gain_coef = 14'h1425;
                4'h5:    gain_coef = 14'h1556;
                4'h6:    gain_coef = 14'h169A;
                4'h7:    gain_coef = 14'h17F1;
                4'h8:    gain_coef = 14'h195C;
                4'h9:    gain_coef = 14'h1ADD;
                4'hA:    gain_coef = 14'h1C74;
                4'hB:    gain_coef = 14'h1E24;
                default: gain_coef = 14'h1FED;
            endcase
        end
    endfunction

    // Self-synchronous scrambler 1 + x^14 + x^15, MSB first; {state, data}
    function [30:0] scramble;
        input [15:0] d;
        input [14:0] s;
        integer      i;
        reg   [14:0] st;
        reg   [15:0] o;
        begin
            st = s;
            o  = 16'h0000;
            for (i = 15; i >= 0; i = i - 1)
            begin
                o[i] = d[i] ^ st[13] ^ st[14];
                st   = {st[13:0], o[i]};
            end
            scramble = {st, o};
        end
    endfunction

    function [13:0] reverse14;
        input [13:0] v;
        integer      i;
        begin
            reverse14 = 14'h0000;
            for (i = 0; i < 14; i = i + 1)
                reverse14[i] = v[13 - i];
        end
    endfunction

    // ***************************************************
    // Registers
    // ***************************************************
    reg [7:0]  pat_hi_q;
    reg [7:0]  pat_lo_q;
    reg [7:0]  pwr_ref_q;
    reg [7:0]  gain_pat_q;
    reg [7:0]  link_ctl_q;
    reg [1:0]  state_q;
    reg [1:0]  state_d;

    wire [7:0]  idx          = avs_address_i[9:2];
    wire        pdn          = pwr_ref_q[`ADL_PWR_PDN_BIT];
    wire [3:0]  gain_sel     = gain_pat_q[`ADL_GAIN_MSB:`ADL_GAIN_LSB];
    wire        gain_byp     = gain_pat_q[`ADL_GAIN_BYP_BIT];
    wire [2:0]  pat_sel      = gain_pat_q[`ADL_PAT_MSB:`ADL_PAT_LSB];
    wire [13:0] user_pattern = {pat_hi_q, pat_lo_q[7:2]};

    reg [7:0] rd_byte;
    always @*
    begin
        case (idx)
            `ADL_IDX_PAT_HI:     rd_byte = pat_hi_q;
            `ADL_IDX_PAT_LO:     rd_byte = {pat_lo_q[7:2], 2'b00};
            `ADL_IDX_PWR_REF:    rd_byte = pwr_ref_q;
            `ADL_IDX_GAIN_PAT:   rd_byte = gain_pat_q;
            `ADL_IDX_LINK_ALIGN: rd_byte = link_ctl_q;
            `ADL_IDX_STATUS:     rd_byte = {5'b00000, pdn, state_q};
            default:             rd_byte = 8'h00;
        endcase
    end

    // Request answered one cycle after it appears, taken on the low-wait edge
    wire wr_take = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
            pat_hi_q          <= `ADL_RST_BYTE;
            pat_lo_q          <= `ADL_RST_BYTE;
            pwr_ref_q         <= `ADL_RST_BYTE;
            gain_pat_q        <= `ADL_RST_BYTE;
            link_ctl_q        <= `ADL_RST_BYTE;
        end
        else
        begin
            if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
            begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o    <= {24'h00_0000, rd_byte};
            end
            else
            begin
                avs_waitrequest_o <= 1'b1;
            end
            if (wr_take)
            begin
                case (idx)
                    `ADL_IDX_PAT_HI:     pat_hi_q   <= avs_writedata_i[7:0];
                    `ADL_IDX_PAT_LO:     pat_lo_q   <= avs_writedata_i[7:0];
                    `ADL_IDX_PWR_REF:    pwr_ref_q  <= avs_writedata_i[7:0];
                    `ADL_IDX_GAIN_PAT:   gain_pat_q <= avs_writedata_i[7:0];
                    `ADL_IDX_LINK_ALIGN: link_ctl_q <= avs_writedata_i[7:0];
                    default:             ;
                endcase
            end
        end
    end

    // ***************************************************
    // Fine gain, scaled about mid-scale and saturated
    // ***************************************************
    reg signed [14:0] centred;
    reg signed [29:0] prod;
    reg signed [17:0] scaled;
    reg        [13:0] gained;
    always @*
    begin
        centred = $signed({1'b0, adc_data_i}) - 15'sh2000;
        prod    = centred * $signed({1'b0, gain_coef(gain_sel)});
        scaled  = prod[29:12];
        if (scaled > 18'sh01FFF)
            gained = 14'h3FFF;
        else if (scaled < -18'sh02000)
            gained = 14'h0000;
        else
            gained = scaled[13:0] ^ 14'h2000;
        if (gain_byp)
            gained = adc_data_i;
    end

    // ***************************************************
    // Test pattern selection
    // ***************************************************
    reg [13:0] gained_q;
    reg [13:0] ramp_q;
    reg [1:0]  ramp_div_q;
    reg [13:0] pat_d;
    always @*
    begin
        case (pat_sel)
            `ADL_PAT_ADC:  pat_d = gained_q;
            `ADL_PAT_MIN:  pat_d = 14'h0000;
            `ADL_PAT_MAX:  pat_d = 14'h3FFF;
            `ADL_PAT_RAMP: pat_d = ramp_q;
            `ADL_PAT_USER: pat_d = user_pattern;
            // Reserved codes are not to be used; pass samples as a safe fallback
            default:       pat_d = gained_q;
        endcase
    end

    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            gained_q   <= 14'h0000;
            ramp_q     <= 14'h0000;
            ramp_div_q <= 2'h0;
            sample_o   <= 14'h0000;
        end
        else if (!pdn)
        begin
            gained_q   <= gained;
            sample_o   <= pat_d;
            ramp_div_q <= ramp_div_q + 2'h1;
            // 14-bit counter folds from maximum back to minimum by itself
            if (ramp_div_q == `ADL_RAMP_DIV)
                ramp_q <= ramp_q + 14'h0001;
        end
    end

    // ***************************************************
    // Link framing
    // ***************************************************
    wire        flip    = link_ctl_q[`ADL_LNK_FLIP_BIT];
    wire        frame_align_pin  = link_ctl_q[`ADL_LNK_FRAME_ALIGN_PIN_BIT];
    wire        multiframe_align_enable = link_ctl_q[`ADL_LNK_MULTIFRAME_ALIGN_ENABLE_BIT];
    // Two pad zeros stay at the bottom whether or not the sample is flipped
    wire [15:0] word    = flip ? {reverse14(sample_o), 2'b00}
                               : {sample_o, 2'b00};

    reg [4:0]  frame_q;
    reg [1:0]  ilas_mf_q;
    reg [14:0] scr_q;
    reg [7:0]  prev_lo_q;
    reg        idle_first_q;
    wire       mf_end = (frame_q == MF_FRAMES - 1);

    reg [30:0] scr_res;
    reg [15:0] dat_d;
    reg [1:0]  k_d;
    always @*
    begin
        scr_res = scramble(word, scr_q);
        dat_d   = scramble_enable_i ? scr_res[15:0] : word;
        k_d     = 2'b00;
        state_d = state_q;
        case (state_q)
            ST_CGS:
            begin
                if (link_ctl_q[`ADL_LNK_IDLE_BIT])
                    dat_d = {`ADL_K28_5, idle_first_q ? `ADL_D5_6 : `ADL_D16_2};
                else
                    dat_d = {`ADL_K28_5, `ADL_K28_5};
                k_d = link_ctl_q[`ADL_LNK_IDLE_BIT] ? 2'b10 : 2'b11;
                if (sync_n_i && frame_q == 5'd0)
                    state_d = link_ctl_q[`ADL_LNK_ILAS_BIT] ? ST_ILAS : ST_DATA;
            end
            ST_ILAS:
            begin
                dat_d = {3'b000, frame_q, 3'b000, frame_q};
                if (frame_q == 5'd0)
                begin
                    dat_d[15:8] = `ADL_K28_0;
                    k_d[1]      = 1'b1;
                end
                if (mf_end)
                begin
                    dat_d[7:0] = `ADL_K28_3;
                    k_d[0]     = 1'b1;
                    if (ilas_mf_q == `ADL_ILAS_MFRAMES)
                        state_d = ST_DATA;
                end
            end
            ST_DATA:
            begin
                if (link_ctl_q[`ADL_LNK_TEST_BIT])
                    dat_d = {`ADL_D21_5, `ADL_D21_5};
                else if (scramble_enable_i)
                begin
                    if (multiframe_align_enable && mf_end && dat_d[7:0] == `ADL_K28_3)
                        k_d[0] = 1'b1;
                    else if (frame_align_pin && dat_d[7:0] == `ADL_K28_7)
                        k_d[0] = 1'b1;
                end
                else if (dat_d[7:0] == prev_lo_q)
                begin
                    if (multiframe_align_enable && mf_end)
                    begin
                        dat_d[7:0] = `ADL_K28_3;
                        k_d[0]     = 1'b1;
                    end
                    else if (frame_align_pin)
                    begin
                        dat_d[7:0] = `ADL_K28_7;
                        k_d[0]     = 1'b1;
                    end
                end
                // With both align bits and the test bit clear the low octet passes untouched
            end
            default: state_d = ST_CGS;
        endcase
        if (!sync_n_i)
            state_d = ST_CGS;
    end

    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_q      <= ST_CGS;
            frame_q      <= 5'd0;
            ilas_mf_q    <= 2'h0;
            scr_q        <= 15'h7FFF;
            prev_lo_q    <= 8'h00;
            idle_first_q <= 1'b1;
            link_data_o  <= 16'h0000;
            link_is_k_o  <= 2'b00;
            link_valid_o <= 1'b0;
        end
        else if (pdn)
        begin
            // Link goes quiet and restarts with code group sync
            state_q      <= ST_CGS;
            frame_q      <= 5'd0;
            idle_first_q <= 1'b1;
            link_data_o  <= 16'h0000;
            link_is_k_o  <= 2'b00;
            link_valid_o <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            frame_q      <= mf_end ? 5'd0 : frame_q + 5'd1;
            idle_first_q <= (state_q == ST_CGS) ? 1'b0 : 1'b1;
            link_data_o  <= dat_d;
            link_is_k_o  <= k_d;
            link_valid_o <= 1'b1;
            if (state_q != ST_ILAS)
                ilas_mf_q <= 2'h0;
            else if (mf_end)
                ilas_mf_q <= ilas_mf_q + 2'h1;
            if (state_q == ST_DATA && scramble_enable_i)
                scr_q <= scr_res[30:16];
            if (state_q == ST_DATA)
                prev_lo_q <= scramble_enable_i ? scr_res[7:0] : word[7:0];
        end
    end

endmodule // adl_tx_datapath
